// ==== hdl/pwe_pkg.sv ====
// Notes on behaviour
// - Wake packet match sets event bit 2
// - Link up sets event bit 1, PHY ports
// - Cable energy sets event bit 0, PHY ports
// - Enable bit 2 gates wake packet event
// - Enable bit 1 gates link-up event
// - Enable bit 0 gates energy event
// - Registers at 0xN013, 0xN017, 0xN01B, eight bits
// - Status bit 3 is SGMII done, port 7
// - Status bit 2 summarizes PTP, PHY ports
// - Status bit 1 summarizes PHY interrupts
// - Status bit 0 raised by access rule counter
// - Status bit 0 clears on mask toggle
// - Status raises port interrupt only when mask enables it
// - Mask at 0xN01F, zero enables
package pwe_pkg;
   // Port count and register width
   localparam int NPORTS = 7;
   localparam int RW     = 8;
   // Byte address layout: port in [15:12], register offset in [11:0]
   localparam int PORT_LSB = 12;
   localparam logic [11:0] OFF_EVENT  = 12'h013;
   localparam logic [11:0] OFF_ENABLE = 12'h017;
   localparam logic [11:0] OFF_STATUS = 12'h01b;
   localparam logic [11:0] OFF_MASK   = 12'h01f;
   // Global interrupt block registers
   localparam logic [15:0] ADDR_GSTAT = 16'h0010;
   localparam logic [15:0] ADDR_GMASK = 16'h0014;
   // Event bit positions
   localparam int EV_PKT    = 2;
   localparam int EV_LINK   = 1;
   localparam int EV_ENERGY = 0;
   // Status bit positions
   localparam int ST_SGMII = 3;
   localparam int ST_PTP   = 2;
   localparam int ST_PHY   = 1;
   localparam int ST_RULE  = 0;
   // Field widths and reset values
   localparam int EVW = 3;
   localparam int STW = 4;
   localparam logic [RW-1:0] RST_ZERO = 8'h00;
   // Ports with integrated PHY (bit p-1 for port p) and SGMII port
   localparam logic [NPORTS-1:0] PHY_PORTS = 7'h1f;
   localparam int SGMII_PORT = 7;
   // Bus answer to an unmapped address
   localparam logic [31:0] UNMAPPED = 32'h0000_0000;
endpackage

// ==== hdl/pwe_port.sv ====
// One port slice: wake events, enables, status and mask
module pwe_port #(
   parameter int  PORT_NUM = 1,
   parameter bit  HAS_PHY  = 1'b1
) (
   // Clock and reset
   input  wire logic    mclk,
   input  wire logic    rst_b,
   // Synchronised event inputs
   input  wire logic    pktMatch,
   input  wire logic    linkUp,
   input  wire logic    energy,
   input  wire logic    sgmiiDone,
   input  wire logic    ptpIrq,
   input  wire logic    phyIrq,
   input  wire logic    ruleIrq,
   // Register view
   pwe_port_if.port     rp
);
   logic [pwe_pkg::EVW-1:0] evSet;   // Hardware event set terms
   logic [pwe_pkg::EVW-1:0] ev_q;    // Sticky wake events
   logic [pwe_pkg::EVW-1:0] en_q;    // Wake enables
   logic [pwe_pkg::STW-1:0] mk_q;    // Mask
   logic                    rule_q;  // Sticky access rule status

   // Only PHY ports carry link and energy events
   always_comb begin
      evSet                      = '0;
      evSet[pwe_pkg::EV_PKT]     = pktMatch;
      evSet[pwe_pkg::EV_LINK]    = HAS_PHY && linkUp;
      evSet[pwe_pkg::EV_ENERGY]  = HAS_PHY && energy;
   end

   // Sticky events; set wins over a same-cycle clear
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ev_q <= '0;
      end else begin
         ev_q <= (ev_q & ~rp.evClr) | evSet;
      end
   end

   // Enable register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         en_q <= '0;
      end else if (rp.enWr) begin
         en_q <= rp.wdata[pwe_pkg::EVW-1:0];
      end
   end

   // Mask register, reserved bits not stored
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mk_q <= '0;
      end else if (rp.mkWr) begin
         mk_q <= rp.wdata[pwe_pkg::STW-1:0];
      end
   end

   // Access rule status: held until mask bit 0 changes value
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rule_q <= 1'b0;
      end else if (ruleIrq) begin
         rule_q <= 1'b1;
      end else if (rp.mkWr && (rp.wdata[pwe_pkg::ST_RULE] != mk_q[pwe_pkg::ST_RULE])) begin
         rule_q <= 1'b0;
      end
   end

   // Summary bits; level sources pass through as live status
   always_comb begin
      rp.status                   = '0;
      rp.status[pwe_pkg::ST_SGMII] = (PORT_NUM == pwe_pkg::SGMII_PORT) && sgmiiDone;
      rp.status[pwe_pkg::ST_PTP]   = HAS_PHY && ptpIrq;
      rp.status[pwe_pkg::ST_PHY]   = HAS_PHY && phyIrq;
      rp.status[pwe_pkg::ST_RULE]  = rule_q;
   end

   assign rp.events  = ev_q;
   assign rp.enables = en_q;
   assign rp.mask    = mk_q;
   assign rp.wakeOut = |(ev_q & en_q);
   assign rp.irqOut  = |(rp.status & ~mk_q);

   // Assertions
   ev_sticky_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (ev_q[pwe_pkg::EV_PKT] && !rp.evClr[pwe_pkg::EV_PKT]) |=> ev_q[pwe_pkg::EV_PKT])
      else $error("Wake event dropped without clear");
   pkt_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
      pktMatch |=> ev_q[pwe_pkg::EV_PKT])
      else $error("Packet match not latched");
   rule_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (rule_q && !rp.mkWr) |=> rule_q)
      else $error("Access rule status lost without mask toggle");
   rule_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ruleIrq |=> rule_q)
      else $error("Access rule status not set");
   mask_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (rp.status[pwe_pkg::ST_RULE] && !mk_q[pwe_pkg::ST_RULE]) |-> rp.irqOut)
      else $error("Unmasked status not reported");
endmodule

// ==== hdl/pwe_port_if.sv ====
// Per-port register view shared between top and port slice
interface pwe_port_if;
   logic [pwe_pkg::EVW-1:0] evClr;    // Write-one-to-clear strobe of events
   logic                    enWr;     // Enable register write strobe
   logic                    mkWr;     // Mask register write strobe
   logic [pwe_pkg::RW-1:0]  wdata;    // Write byte
   logic [pwe_pkg::EVW-1:0] events;   // Latched wake events
   logic [pwe_pkg::EVW-1:0] enables;  // Wake enables
   logic [pwe_pkg::STW-1:0] status;   // Raw interrupt status
   logic [pwe_pkg::STW-1:0] mask;     // Interrupt mask, one disables
   logic                    wakeOut;  // Enabled wake event present
   logic                    irqOut;   // Unmasked status present
   modport top  (output evClr, enWr, mkWr, wdata,
                 input events, enables, status, mask, wakeOut, irqOut);
   modport port (input evClr, enWr, mkWr, wdata,
                 output events, enables, status, mask, wakeOut, irqOut);
endinterface

// ==== hdl/pwe_top.sv ====
// Per-port wake event and interrupt status block with Avalon-MM slave
//
// The Avalon-MM slave port was decided locally.
module pwe_top #(
   parameter int NPORTS = pwe_pkg::NPORTS
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Avalon-MM slave, byte address
   input  wire logic [15:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Event sources, one bit per port (bit 0 is port 1), asynchronous
   input  wire logic [6:0]  wakePktMatch,
   input  wire logic [6:0]  linkUpDetect,
   input  wire logic [6:0]  energyDetect,
   input  wire logic [6:0]  sgmiiAnDone,
   input  wire logic [6:0]  ptpIrq,
   input  wire logic [6:0]  phyIrq,
   input  wire logic [6:0]  ruleCountIrq,
   // Outputs
   output logic             powerEventOut,
   output logic             portIrqOut,
   output logic             irq
);
   localparam int NSRC = 7;                       // Synchronised source groups

   logic [NSRC*NPORTS-1:0] rawIn;                 // Flattened source bits
   logic [NSRC*NPORTS-1:0] meta_q;                // First sync stage
   logic [NSRC*NPORTS-1:0] sync_q;                // Second sync stage
   logic [NSRC*NPORTS-1:0] prev_q;                // For edge detect
   logic [NPORTS-1:0]      wakeVec;               // Per-port wake summary
   logic [NPORTS-1:0]      irqVec;                // Per-port irq summary
   logic [NPORTS-1:0][pwe_pkg::RW-1:0] evRd;      // Read views
   logic [NPORTS-1:0][pwe_pkg::RW-1:0] enRd;
   logic [NPORTS-1:0][pwe_pkg::RW-1:0] stRd;
   logic [NPORTS-1:0][pwe_pkg::RW-1:0] mkRd;
   logic [3:0]             portSel;               // Decoded port number
   logic [11:0]            offSel;                // Decoded register offset
   logic                   portOk;                // Port in range
   logic                   accept;                // Request taken this cycle
   logic                   busy_q;                // Answer phase
   logic [1:0]             gstat_q;               // Sticky global status
   logic [1:0]             gmask_q;               // Global mask, one enables
   logic [1:0]             gEvent;                // Rising wake/irq summaries
   logic                   gStatRd;               // Read of global status
   logic                   wakeAny_q;
   logic                   irqAny_q;

   assign rawIn = {ruleCountIrq, phyIrq, ptpIrq, sgmiiAnDone,
                   energyDetect, linkUpDetect, wakePktMatch};

   // Two-stage synchronisers; only stage two is read
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= rawIn;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Address decode: port in high nibble, offset in the rest
   assign portSel = avs_address[15:pwe_pkg::PORT_LSB];
   assign offSel  = avs_address[pwe_pkg::PORT_LSB-1:0];
   assign portOk  = (portSel >= 4'h1) && (portSel <= 4'(NPORTS));
   // One wait cycle: request taken on the first cycle, answered on the next
   assign accept  = (avs_read || avs_write) && !busy_q;

   // Port slices; packet, link, energy and rule inputs are rising edges, status sources are synchronised levels
   genvar p;
   generate
      for (p = 0; p < NPORTS; p++) begin : g_port
         pwe_port_if rp ();
         logic hit;
         logic wrB0;
         assign hit  = accept && portOk && (portSel == 4'(p + 1));
         assign wrB0 = hit && avs_write && avs_byteenable[0];
         // Event register is write-one-to-clear
         assign rp.evClr = (wrB0 && offSel == pwe_pkg::OFF_EVENT) ?
                           avs_writedata[pwe_pkg::EVW-1:0] : '0;
         assign rp.enWr  = wrB0 && (offSel == pwe_pkg::OFF_ENABLE);
         assign rp.mkWr  = wrB0 && (offSel == pwe_pkg::OFF_MASK);
         assign rp.wdata = avs_writedata[pwe_pkg::RW-1:0];
         pwe_port #(
            .PORT_NUM (p + 1),
            .HAS_PHY  (pwe_pkg::PHY_PORTS[p])
         ) u_port (
            .mclk      (mclk),
            .rst_b     (rst_b),
            .pktMatch  (sync_q[0*NPORTS+p] && !prev_q[0*NPORTS+p]),
            .linkUp    (sync_q[1*NPORTS+p] && !prev_q[1*NPORTS+p]),
            .energy    (sync_q[2*NPORTS+p] && !prev_q[2*NPORTS+p]),
            .sgmiiDone (sync_q[3*NPORTS+p]),
            .ptpIrq    (sync_q[4*NPORTS+p]),
            .phyIrq    (sync_q[5*NPORTS+p]),
            .ruleIrq   (sync_q[6*NPORTS+p] && !prev_q[6*NPORTS+p]),
            .rp        (rp)
         );
         // Reserved bits read as zero
         assign evRd[p]   = {{(pwe_pkg::RW-pwe_pkg::EVW){1'b0}}, rp.events};
         assign enRd[p]   = {{(pwe_pkg::RW-pwe_pkg::EVW){1'b0}}, rp.enables};
         assign stRd[p]   = {{(pwe_pkg::RW-pwe_pkg::STW){1'b0}}, rp.status};
         assign mkRd[p]   = {{(pwe_pkg::RW-pwe_pkg::STW){1'b0}}, rp.mask};
         assign wakeVec[p] = rp.wakeOut;
         assign irqVec[p]  = rp.irqOut;
      end
   endgenerate

   // Wait state: waitrequest high on the taking cycle, low on the answer
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q          <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         busy_q          <= accept;
         avs_waitrequest <= !accept;
      end
   end

   // Read data mux, registered on the taking cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= pwe_pkg::UNMAPPED;
      end else if (accept && avs_read) begin
         avs_readdata <= pwe_pkg::UNMAPPED;
         if (portOk) begin
            unique case (offSel)
               pwe_pkg::OFF_EVENT:  avs_readdata <= {24'h000000, evRd[portSel - 4'h1]};
               pwe_pkg::OFF_ENABLE: avs_readdata <= {24'h000000, enRd[portSel - 4'h1]};
               pwe_pkg::OFF_STATUS: avs_readdata <= {24'h000000, stRd[portSel - 4'h1]};
               pwe_pkg::OFF_MASK:   avs_readdata <= {24'h000000, mkRd[portSel - 4'h1]};
               default:             avs_readdata <= pwe_pkg::UNMAPPED;
            endcase
         end else if (avs_address == pwe_pkg::ADDR_GSTAT) begin
            avs_readdata <= {30'h0, gstat_q};
         end else if (avs_address == pwe_pkg::ADDR_GMASK) begin
            avs_readdata <= {30'h0, gmask_q};
         end
      end
   end

   // Power event and port summary outputs, registered
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wakeAny_q     <= 1'b0;
         irqAny_q      <= 1'b0;
         powerEventOut <= 1'b0;
         portIrqOut    <= 1'b0;
      end else begin
         wakeAny_q     <= |wakeVec;
         irqAny_q      <= |irqVec;
         powerEventOut <= |wakeVec;
         portIrqOut    <= |irqVec;
      end
   end

   // Global sticky status: bit 0 wake rise, bit 1 irq rise; read clears
   assign gEvent  = {(|irqVec) && !irqAny_q, (|wakeVec) && !wakeAny_q};
   assign gStatRd = accept && avs_read && (avs_address == pwe_pkg::ADDR_GSTAT);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gstat_q <= 2'h0;
      end else begin
         // New event in the read cycle survives the clear
         gstat_q <= (gStatRd ? 2'h0 : gstat_q) | gEvent;
      end
   end

   // Global mask register, one enables
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gmask_q <= 2'h0;
      end else if (accept && avs_write && avs_byteenable[0]
                   && avs_address == pwe_pkg::ADDR_GMASK) begin
         gmask_q <= avs_writedata[1:0];
      end
   end

   // Level interrupt output
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |((gstat_q & ~(gStatRd ? gstat_q : 2'h0) | gEvent) & gmask_q);
      end
   end

   // Assertions
   power_follow_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ##1 (powerEventOut == $past(|wakeVec)))
      else $error("Power event does not follow enabled events");
   wait_one_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (avs_read && avs_waitrequest && !busy_q) |=> !avs_waitrequest)
      else $error("Bus answer not in one cycle");
   power_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (powerEventOut && |wakeVec) |=> powerEventOut)
      else $error("Power event dropped while events pending");
endmodule

// ==== test/tb_top.sv ====
// Register-level bench for the port wake event and interrupt block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk;            // Core clock
   logic        rst_b;           // Async reset
   logic [15:0] avs_address;     // Bus address
   logic        avs_read;        // Read request
   logic        avs_write;       // Write request
   logic [31:0] avs_writedata;   // Write data, byte 0 used
   logic [31:0] avs_readdata;    // Read data
   logic        avs_waitrequest; // Slave busy
   logic [6:0]  evs [0:3];       // Edge events: energy, link, packet, counter
   logic [6:0]  lvs [1:3];       // Level sources: PHY, PTP, SGMII
   logic        powerEventOut;   // Wake output
   logic        portIrqOut;      // Port interrupt summary
   logic        irq;             // Global interrupt
   logic [7:0]  rd;              // Last read byte
   int          mismatches;      // Failed comparisons
   int          check_count;     // All comparisons

   pwe_top dut_u (
      .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .wakePktMatch(evs[2]), .linkUpDetect(evs[1]), .energyDetect(evs[0]),
      .sgmiiAnDone(lvs[3]), .ptpIrq(lvs[2]), .phyIrq(lvs[1]), .ruleCountIrq(evs[3]),
      .powerEventOut(powerEventOut), .portIrqOut(portIrqOut), .irq(irq));

   // Free-running 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Verdict and end of run
   task complete_run;
      $display("mismatches %0d of %0d checks", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Byte compare
   task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Single-bit output compare
   task chk1(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Port-relative byte address
   function automatic logic [15:0] ra(input int p, input logic [11:0] off);
      return {p[3:0], off};
   endfunction

   // One bus transfer; request held until waitrequest is sampled low
   task bus(input logic wr, input logic [15:0] addr, input logic [7:0] wd);
      int n;
      n = 0;
      avs_address   <= addr;
      avs_read      <= ~wr;
      avs_write     <= wr;
      avs_writedata <= {24'h00_0000, wd};
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      // Gap edge so the next request is not driven in the same step
      @(posedge mclk);
      if (n >= 50) begin
         mismatches++;
         $display("wrong value bus answer expected ack seen none");
         complete_run;
      end
   endtask

   task wr(input logic [15:0] addr, input logic [7:0] wd);
      bus(1'b1, addr, wd);
   endtask

   task rdc(input string name, input logic [15:0] addr, input logic [7:0] exp);
      bus(1'b0, addr, 8'h00);
      chk8(name, exp, rd);
   endtask

   // Event path is sync plus edge plus latch, well inside eight cycles
   task settle;
      repeat (8) @(posedge mclk);
   endtask

   // Short pulse on one edge-event source of one port
   task pulse(input int k, input int p);
      evs[k][p-1] <= 1'b1;
      repeat (3) @(posedge mclk);
      evs[k][p-1] <= 1'b0;
      settle;
   endtask

   // Expected raw status: PHY ports 1..5, SGMII only port 7
   function automatic logic [7:0] stExp(input int p, input int s);
      return (((s < 3) && (p <= 5)) || ((s == 3) && (p == 7))) ? (8'h01 << s) : 8'h00;
   endfunction

   initial begin
      mismatches = 0;
      check_count = 0;
      rst_b = 1'b0;
      avs_address = 16'h0000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      for (int i = 0; i < 4; i++) evs[i] = 7'h00;
      for (int i = 1; i < 4; i++) lvs[i] = 7'h00;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      // Reset values of all four registers on an edge port pair
      foreach (evs[i]) begin
         rdc("reset", ra(1, 12'h013 + 12'(4 * i)), 8'h00);
         rdc("reset", ra(7, 12'h013 + 12'(4 * i)), 8'h00);
      end
      rdc("unmapped", 16'h0030, 8'h00);
      // Each wake event: latch, gating by its own enable only, clear
      for (int b = 0; b < 3; b++) begin
         pulse(b, 1);
         rdc("event", ra(1, pwe_pkg::OFF_EVENT), 8'h01 << b);
         wr(ra(1, pwe_pkg::OFF_ENABLE), 8'h07 ^ (8'h01 << b));
         settle;
         chk1("wake other enables", 1'b0, powerEventOut);
         wr(ra(1, pwe_pkg::OFF_ENABLE), 8'h01 << b);
         settle;
         chk1("wake enabled", 1'b1, powerEventOut);
         rdc("event sticky", ra(1, pwe_pkg::OFF_EVENT), 8'h01 << b);
         wr(ra(1, pwe_pkg::OFF_EVENT), 8'h01 << b);
         settle;
         chk1("wake cleared", 1'b0, powerEventOut);
         rdc("event cleared", ra(1, pwe_pkg::OFF_EVENT), 8'h00);
         wr(ra(1, pwe_pkg::OFF_ENABLE), 8'h00);
      end
      // MAC-only port: link and energy absent, packet present
      pulse(0, 6);
      pulse(1, 6);
      pulse(2, 6);
      rdc("mac port event", ra(6, pwe_pkg::OFF_EVENT), 8'h04);
      wr(ra(6, pwe_pkg::OFF_EVENT), 8'h07);
      // Another port drives the shared output; global interrupt path
      pulse(2, 3);
      chk1("irq masked", 1'b0, irq);
      wr(ra(3, pwe_pkg::OFF_ENABLE), 8'hff);
      rdc("enable reserved", ra(3, pwe_pkg::OFF_ENABLE), 8'h07);
      wr(pwe_pkg::ADDR_GMASK, 8'h01);
      settle;
      chk1("wake port 3", 1'b1, powerEventOut);
      chk1("irq raised", 1'b1, irq);
      rdc("global status", pwe_pkg::ADDR_GSTAT, 8'h01);
      settle;
      chk1("irq cleared", 1'b0, irq);
      wr(ra(3, pwe_pkg::OFF_EVENT), 8'h04);
      // Level status sources, per-port presence and masking
      for (int s = 1; s < 4; s++) begin
         lvs[s] <= 7'h61;
         settle;
         rdc("status p1", ra(1, pwe_pkg::OFF_STATUS), stExp(1, s));
         rdc("status p6", ra(6, pwe_pkg::OFF_STATUS), stExp(6, s));
         rdc("status p7", ra(7, pwe_pkg::OFF_STATUS), stExp(7, s));
         chk1("port irq on", 1'b1, portIrqOut);
         wr(ra(1, pwe_pkg::OFF_MASK), 8'h01 << s);
         wr(ra(7, pwe_pkg::OFF_MASK), 8'h01 << s);
         settle;
         chk1("port irq masked", 1'b0, portIrqOut);
         lvs[s] <= 7'h00;
         wr(ra(1, pwe_pkg::OFF_MASK), 8'h00);
         wr(ra(7, pwe_pkg::OFF_MASK), 8'h00);
         settle;
         rdc("status gone", ra(7, pwe_pkg::OFF_STATUS), 8'h00);
      end
      // Counter interrupt: sticky, cleared only by toggling its mask bit
      pulse(3, 2);
      rdc("rule status", ra(2, pwe_pkg::OFF_STATUS), 8'h01);
      wr(ra(2, pwe_pkg::OFF_MASK), 8'h02);
      rdc("mask readback", ra(2, pwe_pkg::OFF_MASK), 8'h02);
      rdc("rule kept", ra(2, pwe_pkg::OFF_STATUS), 8'h01);
      chk1("rule irq", 1'b1, portIrqOut);
      wr(ra(2, pwe_pkg::OFF_MASK), 8'h03);
      rdc("rule toggled", ra(2, pwe_pkg::OFF_STATUS), 8'h00);
      wr(ra(2, pwe_pkg::OFF_MASK), 8'h00);
      settle;
      chk1("rule irq gone", 1'b0, portIrqOut);
      // Port summary rise waits in global bit 1 until enabled and read
      chk1("irq bit 1 masked", 1'b0, irq);
      wr(pwe_pkg::ADDR_GMASK, 8'h03);
      rdc("global mask", pwe_pkg::ADDR_GMASK, 8'h03);
      settle;
      chk1("irq port summary", 1'b1, irq);
      rdc("global status port", pwe_pkg::ADDR_GSTAT, 8'h02);
      settle;
      chk1("irq port cleared", 1'b0, irq);
      complete_run;
   end
endmodule
